/* File: verilog/lcdft_pkg.sv */
// Constants, types and state layout of the LCD frame timing controller
`default_nettype none

package lcdft_pkg;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int unsigned LCDFT_ADR_W      = 12;
  localparam logic [9:0]  LCDFT_IDX_FLAG   = 10'h00C;
  localparam logic [9:0]  LCDFT_IDX_IEN    = 10'h08C;
  localparam logic [9:0]  LCDFT_IDX_SEGSEL = 10'h10D;
  localparam logic [9:0]  LCDFT_IDX_PSC    = 10'h10E;
  localparam logic [9:0]  LCDFT_IDX_CTRL   = 10'h10F;
  localparam logic [5:0]  LCDFT_PIX_PAGE   = 6'h11;
  localparam int unsigned LCDFT_PIX_DEPTH  = 16;
  localparam int unsigned LCDFT_PIX_AW     = 4;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned LCDFT_CTRL_EN    = 7;
  localparam int unsigned LCDFT_CTRL_SLP   = 6;
  localparam int unsigned LCDFT_CTRL_INTERNAL_BIAS_GENERATOR_ENABLE  = 4;
  localparam int unsigned LCDFT_CTRL_CS    = 2;
  localparam int unsigned LCDFT_CTRL_MUX   = 0;
  localparam int unsigned LCDFT_FLAG_BIT   = 7;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0]  LCDFT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  LCDFT_CTRL_MASK  = 8'hDF;
  localparam logic [3:0]  LCDFT_PSC_RST    = 4'h0;
  localparam logic [7:0]  LCDFT_SEGSEL_RST = 8'hFF;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  LCDFT_CS_SYS     = 2'h0;
  localparam logic [1:0]  LCDFT_CS_AUX     = 2'h1;
  localparam logic [1:0]  LCDFT_MUX_STATIC = 2'h0;
  localparam logic [1:0]  LCDFT_MUX_2      = 2'h1;
  localparam logic [1:0]  LCDFT_MUX_3      = 2'h2;
  localparam logic [1:0]  LCDFT_MUX_4      = 2'h3;
  localparam logic [1:0]  LCDFT_LVL_V0     = 2'h0;
  localparam logic [1:0]  LCDFT_LVL_V1     = 2'h1;
  localparam logic [1:0]  LCDFT_LVL_V2     = 2'h2;
  localparam logic [1:0]  LCDFT_LVL_V3     = 2'h3;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam int unsigned LCDFT_SYS_DIV    = 256;
  localparam int unsigned LCDFT_FRAME_STD  = 128;
  localparam int unsigned LCDFT_FRAME_MUX3 = 96;
  localparam logic [7:0]  LCDFT_DIV_LAST   = 8'(LCDFT_SYS_DIV - 1);
  localparam logic [6:0]  LCDFT_FLAST_STD  = 7'(LCDFT_FRAME_STD - 1);
  localparam logic [6:0]  LCDFT_FLAST_MUX3 = 7'(LCDFT_FRAME_MUX3 - 1);
  localparam logic [6:0]  LCDFT_PMASK_1    = 7'h7F;
  localparam logic [6:0]  LCDFT_PMASK_2    = 7'h3F;
  localparam logic [6:0]  LCDFT_PMASK_34   = 7'h1F;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCDFT_F_IDLE = 2'b00,
    LCDFT_F_READ = 2'b01,
    LCDFT_F_LAST = 2'b11
  } lcdft_fetch_e;

  typedef struct packed {
    logic         stage;
    logic         ack;
    logic [31:0]  rdat;
    logic [7:0]   ctrl;
    logic [3:0]   psc;
    logic [7:0]   segsel;
    logic         fif;
    logic         fie;
    logic         irq;
    logic         rc_prev;
    logic         aux_prev;
    logic [7:0]   div;
    logic [3:0]   pcnt;
    logic [6:0]   fcnt;
    lcdft_fetch_e fst;
    logic [1:0]   fidx;
    logic [1:0]   fcom;
    logic [31:0]  nxt;
    logic [31:0]  act;
    logic [7:0]   com_lvl;
    logic [63:0]  seg_lvl;
    logic         active;
  } lcdft_state_s;

endpackage

`default_nettype wire

/* File: verilog/lcdft_pix_if.sv */
// Carrier between the controller and its pixel memory
`timescale 1ns/1ps
`default_nettype none

interface lcdft_pix_if #(
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 8
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] bus_addr;
  logic [DW-1:0] bus_rdata;
  logic [AW-1:0] scan_addr;
  logic [DW-1:0] scan_rdata;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output bus_addr,
                input bus_rdata, output scan_addr, input scan_rdata);
  modport mem  (input wr_en, input wr_addr, input wr_data, input bus_addr,
                output bus_rdata, input scan_addr, output scan_rdata);
endinterface

`default_nettype wire

/* File: verilog/lcdft_pixel_mem.sv */
// Pixel storage with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none

module lcdft_pixel_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4,
  parameter int unsigned DW    = 8
) (
  input  wire logic i_core_clk,
  lcdft_pix_if.mem  p
);
  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge i_core_clk) begin
    if (p.wr_en) begin
      mem_q[p.wr_addr] <= p.wr_data;
    end
    p.bus_rdata  <= mem_q[p.bus_addr];
    p.scan_rdata <= mem_q[p.scan_addr];
  end
endmodule

`default_nettype wire

/* File: verilog/lcdft_top.sv */
// LCD frame timing controller with classic Wishbone register slave
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lcdft_top
  import lcdft_pkg::*;
#(
  parameter int unsigned PIX_DEPTH = LCDFT_PIX_DEPTH
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [LCDFT_ADR_W-1:0] i_wb_adr,
  input  wire logic [31:0]            i_wb_dat,
  input  wire logic [3:0]             i_wb_sel,
  output logic      [31:0]            o_wb_dat,
  output logic                        o_wb_ack,
  input  wire logic                   i_sleep,
  input  wire logic                   i_rc_osc_clk,
  input  wire logic                   i_aux_osc_clk,
  input  wire logic [31:0]            i_port_out_en,
  output logic      [31:0]            o_port_out_en,
  output logic      [31:0]            o_pin_lcd_func,
  output logic      [2:0]             o_pin_com_func,
  output logic      [7:0]             o_com_lvl,
  output logic      [63:0]            o_seg_lvl,
  output logic                        o_frame_irq,
  output logic                        o_rc_osc_en,
  output logic                        o_bias_gen_en,
  output logic                        o_display_active
);

  // ---------------------------------------------------------------
  // State and pixel memory
  // ---------------------------------------------------------------
  lcdft_state_s s_q;
  lcdft_state_s s_d;

  lcdft_pix_if #(.AW(LCDFT_PIX_AW), .DW(8)) pix ();

  lcdft_pixel_mem #(
    .DEPTH (PIX_DEPTH),
    .AW    (LCDFT_PIX_AW),
    .DW    (8)
  ) u_mem (
    .i_core_clk (i_core_clk),
    .p          (pix)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [9:0] bus_idx;
  logic       bus_req;
  logic       bus_wr;
  logic       is_pix;
  logic       en;
  logic [1:0] mux;
  logic [1:0] cs;
  logic       stop;
  logic       run;
  logic       tick_s;
  logic       tick_p;
  logic [6:0] frame_last;
  logic [6:0] pmask;
  logic [6:0] pos;
  logic [1:0] com_now;
  logic [1:0] com_next;
  logic       half;
  logic       fetch_go;
  logic       boundary;
  logic       flag_set;
  logic [1:0] cap_idx;
  logic [31:0] seg_func;
  logic [31:0] com_pins;

  assign bus_idx = i_wb_adr[11:2];
  assign bus_req = i_wb_cyc & i_wb_stb & ~s_q.ack & ~s_q.stage;
  assign bus_wr  = s_q.stage & i_wb_we & i_wb_sel[0];
  assign is_pix  = (bus_idx[9:4] == LCDFT_PIX_PAGE);
  assign en      = s_q.ctrl[LCDFT_CTRL_EN];
  assign mux     = s_q.ctrl[LCDFT_CTRL_MUX +: 2];
  assign cs      = s_q.ctrl[LCDFT_CTRL_CS +: 2];

  // Sleep halts on request, or always when the core clock feeds the frame
  assign stop = i_sleep & (s_q.ctrl[LCDFT_CTRL_SLP] | (cs == LCDFT_CS_SYS));
  assign run  = en & ~stop;

  // ---------------------------------------------------------------
  // Source clock and prescale
  // ---------------------------------------------------------------
  always_comb begin
    if (cs == LCDFT_CS_SYS) begin
      tick_s = (s_q.div == LCDFT_DIV_LAST);
    end else if (cs == LCDFT_CS_AUX) begin
      tick_s = i_aux_osc_clk & ~s_q.aux_prev;
    end else begin
      tick_s = i_rc_osc_clk & ~s_q.rc_prev;
    end
  end

  assign tick_p = run & tick_s & (s_q.pcnt == s_q.psc);

  // ---------------------------------------------------------------
  // Frame position
  // ---------------------------------------------------------------
  always_comb begin
    frame_last = (mux == LCDFT_MUX_3) ? LCDFT_FLAST_MUX3 : LCDFT_FLAST_STD;
    case (mux)
      LCDFT_MUX_STATIC: begin
        pmask   = LCDFT_PMASK_1;
        com_now = 2'h0;
      end
      LCDFT_MUX_2: begin
        pmask   = LCDFT_PMASK_2;
        com_now = {1'b0, s_q.fcnt[6]};
      end
      default: begin
        pmask   = LCDFT_PMASK_34;
        com_now = s_q.fcnt[6:5];
      end
    endcase
  end

  assign pos      = s_q.fcnt & pmask;
  assign half     = (pos > (pmask >> 1));
  assign com_next = (com_now == mux) ? 2'h0 : 2'(com_now + 2'h1);
  assign fetch_go = tick_p & (pos == (pmask >> 1));
  assign boundary = tick_p & (pos == pmask);
  assign cap_idx  = 2'(s_q.fidx - 2'h1);
  assign flag_set = run & (s_q.fst == LCDFT_F_LAST) & (s_q.fcom == mux);

  // ---------------------------------------------------------------
  // Pixel memory ports
  // ---------------------------------------------------------------
  assign pix.wr_en     = bus_wr & is_pix & ~i_sleep;
  assign pix.wr_addr   = bus_idx[3:0];
  assign pix.wr_data   = i_wb_dat[7:0];
  assign pix.bus_addr  = bus_idx[3:0];
  assign pix.scan_addr = {s_q.fcom, s_q.fidx};

  // ---------------------------------------------------------------
  // Pin function
  // ---------------------------------------------------------------
  assign seg_func = {{3{s_q.segsel[7]}}, {2{s_q.segsel[6]}}, {7{s_q.segsel[5]}},
                     {4{s_q.segsel[4]}}, {4{s_q.segsel[3]}}, {3{s_q.segsel[2]}},
                     {4{s_q.segsel[1]}}, {5{s_q.segsel[0]}}};

  // Shared common pins follow the common count first
  assign o_pin_com_func = {mux == LCDFT_MUX_4, mux >= LCDFT_MUX_3, mux >= LCDFT_MUX_2};
  // Pin 31 serves as common one, pin 29 as common three
  assign com_pins       = {o_pin_com_func[0], o_pin_com_func[1], o_pin_com_func[2], 29'h0000_0000};
  assign o_pin_lcd_func = seg_func & ~com_pins;
  assign o_port_out_en  = i_port_out_en & ~(seg_func | com_pins);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // Bus slave, answer two cycles after the request
    s_d.stage = bus_req;
    s_d.ack   = s_q.stage;
    if (s_q.stage) begin
      case (bus_idx)
        LCDFT_IDX_FLAG:   s_d.rdat = {24'h00_0000, s_q.fif, 7'h00};
        LCDFT_IDX_IEN:    s_d.rdat = {24'h00_0000, s_q.fie, 7'h00};
        LCDFT_IDX_SEGSEL: s_d.rdat = {24'h00_0000, s_q.segsel};
        LCDFT_IDX_PSC:    s_d.rdat = {28'h000_0000, s_q.psc};
        LCDFT_IDX_CTRL:   s_d.rdat = {24'h00_0000, s_q.ctrl};
        default: begin
          s_d.rdat = is_pix ? {24'h00_0000, pix.bus_rdata} : 32'h0000_0000;
        end
      endcase
    end
    if (bus_wr) begin
      case (bus_idx)
        LCDFT_IDX_IEN:    s_d.fie    = i_wb_dat[LCDFT_FLAG_BIT];
        LCDFT_IDX_SEGSEL: s_d.segsel = i_wb_dat[7:0];
        LCDFT_IDX_PSC:    s_d.psc    = i_wb_dat[3:0];
        LCDFT_IDX_CTRL:   s_d.ctrl   = i_wb_dat[7:0] & LCDFT_CTRL_MASK;
        default: begin
        end
      endcase
    end

    // Frame flag, a new frame event wins over a clear
    if (flag_set) begin
      s_d.fif = 1'b1;
    end else if (bus_wr && bus_idx == LCDFT_IDX_FLAG) begin
      s_d.fif = i_wb_dat[LCDFT_FLAG_BIT];
    end
    s_d.irq = s_d.fif & s_d.fie;

    // Source edge detect and fixed divider
    s_d.rc_prev  = i_rc_osc_clk;
    s_d.aux_prev = i_aux_osc_clk;
    s_d.div      = (run && cs == LCDFT_CS_SYS) ? 8'(s_q.div + 8'h01) : 8'h00;

    if (!run) begin
      // Halted: counters idle, every line at minimum voltage
      s_d.pcnt    = 4'h0;
      s_d.fcnt    = 7'h00;
      s_d.fst     = LCDFT_F_IDLE;
      s_d.fidx    = 2'h0;
      s_d.fcom    = 2'h0;
      s_d.com_lvl = {4{LCDFT_LVL_V0}};
      s_d.seg_lvl = {32{LCDFT_LVL_V0}};
      s_d.active  = 1'b0;
    end else begin
      s_d.active = 1'b1;
      if (tick_s) begin
        s_d.pcnt = (s_q.pcnt == s_q.psc) ? 4'h0 : 4'(s_q.pcnt + 4'h1);
      end
      if (tick_p) begin
        s_d.fcnt = (s_q.fcnt >= frame_last) ? 7'h00 : 7'(s_q.fcnt + 7'h01);
      end
      if (boundary) begin
        s_d.act = s_q.nxt;
      end

      // Fetch the next common's row halfway through the current one
      case (s_q.fst)
        LCDFT_F_IDLE: begin
          if (fetch_go) begin
            s_d.fst  = LCDFT_F_READ;
            s_d.fidx = 2'h0;
            s_d.fcom = com_next;
          end
        end
        LCDFT_F_READ: begin
          if (s_q.fidx != 2'h0) begin
            s_d.nxt[{cap_idx, 3'b000} +: 8] = pix.scan_rdata;
          end
          s_d.fidx = 2'(s_q.fidx + 2'h1);
          if (s_q.fidx == 2'h3) begin
            s_d.fst = LCDFT_F_LAST;
          end
        end
        LCDFT_F_LAST: begin
          s_d.nxt[31:24] = pix.scan_rdata;
          s_d.fidx       = 2'h0;
          s_d.fst        = LCDFT_F_IDLE;
        end
        default: begin
          s_d.fst = LCDFT_F_IDLE;
        end
      endcase

      // Drive levels, polarity reverses each half phase
      for (int c = 0; c < 4; c++) begin
        if (2'(c) > mux) begin
          s_d.com_lvl[2*c +: 2] = LCDFT_LVL_V0;
        end else if (mux == LCDFT_MUX_STATIC) begin
          s_d.com_lvl[2*c +: 2] = half ? LCDFT_LVL_V3 : LCDFT_LVL_V0;
        end else if (2'(c) == com_now) begin
          s_d.com_lvl[2*c +: 2] = half ? LCDFT_LVL_V0 : LCDFT_LVL_V3;
        end else begin
          s_d.com_lvl[2*c +: 2] = half ? LCDFT_LVL_V2 : LCDFT_LVL_V1;
        end
      end
      for (int s = 0; s < 32; s++) begin
        if (com_pins[s]) begin
          s_d.seg_lvl[2*s +: 2] = LCDFT_LVL_V0;
        end else if (mux == LCDFT_MUX_STATIC) begin
          if (s_q.act[s]) begin
            s_d.seg_lvl[2*s +: 2] = half ? LCDFT_LVL_V0 : LCDFT_LVL_V3;
          end else begin
            s_d.seg_lvl[2*s +: 2] = half ? LCDFT_LVL_V3 : LCDFT_LVL_V0;
          end
        end else if (s_q.act[s]) begin
          s_d.seg_lvl[2*s +: 2] = half ? LCDFT_LVL_V3 : LCDFT_LVL_V0;
        end else begin
          s_d.seg_lvl[2*s +: 2] = half ? LCDFT_LVL_V1 : LCDFT_LVL_V2;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q          <= '0;
      s_q.ctrl     <= LCDFT_CTRL_RST;
      s_q.psc      <= LCDFT_PSC_RST;
      s_q.segsel   <= LCDFT_SEGSEL_RST;
      s_q.fst      <= LCDFT_F_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_wb_ack         = s_q.ack;
  assign o_wb_dat         = s_q.rdat;
  assign o_frame_irq      = s_q.irq;
  assign o_com_lvl        = s_q.com_lvl;
  assign o_seg_lvl        = s_q.seg_lvl;
  assign o_display_active = s_q.active;
  assign o_rc_osc_en      = en & cs[1] & ~stop;
  assign o_bias_gen_en    = s_q.ctrl[LCDFT_CTRL_INTERNAL_BIAS_GENERATOR_ENABLE] & ~stop;

endmodule

`default_nettype wire

/* File: dv/lcdft_panel_model.sv */
// Passive panel model that spots frame starts and pixel contrast
`timescale 1ns/1ps
`default_nettype none

module lcdft_panel_model
  import lcdft_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_com_lvl,
  input  wire logic [63:0] i_seg_lvl,
  output int unsigned      o_frames,
  output int unsigned      o_frame_len,
  output logic             o_dark0,
  output logic             o_dark1
);
  logic [1:0]  first_common_line_q;
  int unsigned since_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      first_common_line_q      <= LCDFT_LVL_V0;
      since_q     <= 0;
      o_frames    <= 0;
      o_frame_len <= 0;
      o_dark0     <= 1'b0;
      o_dark1     <= 1'b0;
    end else begin
      first_common_line_q  <= i_com_lvl[1:0];
      since_q <= since_q + 1;
      // Leading edge of the first common marks a frame
      if (i_com_lvl[1:0] == LCDFT_LVL_V3 && first_common_line_q != LCDFT_LVL_V3) begin
        o_frames    <= o_frames + 1;
        o_frame_len <= since_q;
        since_q     <= 1;
      end
      // Dark pixel sees opposite drive to its common
      if (i_com_lvl[1:0] == LCDFT_LVL_V3) begin
        o_dark0 <= i_seg_lvl[1:0] != i_com_lvl[1:0];
        o_dark1 <= i_seg_lvl[3:2] != i_com_lvl[1:0];
      end
    end
  end
endmodule

`default_nettype wire

/* File: dv/lcdft_top_sva.sv */
// Concurrent checks on the frame timing controller ports
`timescale 1ns/1ps
`default_nettype none

module lcdft_top_sva
  import lcdft_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [LCDFT_ADR_W-1:0] i_wb_adr,
  input  wire logic [31:0]            i_port_out_en,
  input  wire logic [31:0]            o_wb_dat,
  input  wire logic                   o_wb_ack,
  input  wire logic [31:0]            o_port_out_en,
  input  wire logic [31:0]            o_pin_lcd_func,
  input  wire logic [2:0]             o_pin_com_func,
  input  wire logic [7:0]             o_com_lvl,
  input  wire logic [63:0]            o_seg_lvl,
  input  wire logic                   o_frame_irq,
  input  wire logic                   o_display_active
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire logic req = i_wb_cyc && i_wb_stb;
  wire logic [2:0] com_rev = {o_pin_com_func[0], o_pin_com_func[1], o_pin_com_func[2]};

  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held beyond one cycle");
  a_ack_latency: assert property ($rose(req) |-> !o_wb_ack ##1 !o_wb_ack ##1 o_wb_ack)
    else $error("ack not on second edge");
  a_rdat_byte: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_psc_upper_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr[11:2] == LCDFT_IDX_PSC |->
    o_wb_dat[7:4] == 4'h0) else $error("prescale upper bits set");
  a_com_pin_order: assert property ((o_pin_com_func & ~{o_pin_com_func[1:0], 1'b1}) == 3'h0)
    else $error("common pins out of order");
  a_com_over_seg: assert property ((o_pin_lcd_func[31:29] & com_rev) == 3'h0)
    else $error("common pin also segment");
  a_port_mask: assert property (o_port_out_en == (i_port_out_en & ~(o_pin_lcd_func | {com_rev, 29'h0})))
    else $error("port enable not masked");
  a_stop_levels: assert property (!o_display_active [*3] |-> o_com_lvl == 8'h00 && o_seg_lvl == 64'h0)
    else $error("levels driven while inactive");
  a_irq_hold: assert property ($fell(o_frame_irq) |-> $past(req && i_wb_we))
    else $error("irq dropped without a write");
endmodule

bind lcdft_top lcdft_top_sva u_sva (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_port_out_en(i_port_out_en), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_port_out_en(o_port_out_en), .o_pin_lcd_func(o_pin_lcd_func), .o_pin_com_func(o_pin_com_func),
  .o_com_lvl(o_com_lvl), .o_seg_lvl(o_seg_lvl), .o_frame_irq(o_frame_irq), .o_display_active(o_display_active)
);

`default_nettype wire

/* File: dv/lcdft_top_tb.sv */
// Register level testbench of the frame timing controller
`timescale 1ns/1ps
`default_nettype none

module lcdft_top_tb
  import lcdft_pkg::*;
;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, sleep = 0, osc = 0;
  logic [11:0] adr = 0;
  logic [31:0] wdat = 0, pen = 32'hFFFF_FFFF, rdat, pout, lcdf;
  logic [3:0]  sel = 0;
  logic [2:0]  comf;
  logic [7:0]  coml, rd;
  logic [63:0] segl;
  logic        ack, irq, rcen, bias, act, dark0, dark1;
  logic [1:0]  div = 0;
  int unsigned frames, flen;
  int          fail_count = 0, checks = 0, cyc_n = 0;
  logic [1:0]  mux_t [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [3:0]  psc_t [4] = '{4'h0, 4'h1, 4'h0, 4'h2};
  int          div_t [4] = '{128, 128, 96, 128};

  lcdft_top u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_sleep(sleep),
    .i_rc_osc_clk(osc), .i_aux_osc_clk(osc), .i_port_out_en(pen), .o_port_out_en(pout),
    .o_pin_lcd_func(lcdf), .o_pin_com_func(comf), .o_com_lvl(coml), .o_seg_lvl(segl),
    .o_frame_irq(irq), .o_rc_osc_en(rcen), .o_bias_gen_en(bias), .o_display_active(act));
  lcdft_panel_model u_panel (.i_core_clk(clk), .i_nrst(nrst), .i_com_lvl(coml), .i_seg_lvl(segl),
    .o_frames(frames), .o_frame_len(flen), .o_dark0(dark0), .o_dark1(dark1));

  // ---------------------------------------------------------------
  // Clock, oscillator of four cycles, watchdog
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (div[0]) osc <= ~osc;
    cyc_n++;
    if (cyc_n == 60000) begin
      fail_count++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic s);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    sel  <= {3'h0, s};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 1'b1);
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00, 1'b1);
    cmp(rd, exp);
  endtask
  task automatic wait_frames(input int n);
    int unsigned t;
    t = frames + n;
    for (int i = 0; i < 20000 && frames < t; i++) @(posedge clk);
    if (frames < t) fail_count++;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp(lcdf, 32'hFFFF_FFFF);
    cmp(comf, 3'h0);
    rchk(LCDFT_IDX_CTRL, LCDFT_CTRL_RST);
    rchk(LCDFT_IDX_SEGSEL, LCDFT_SEGSEL_RST);
    rchk(LCDFT_IDX_FLAG, 8'h00);
    rchk(LCDFT_IDX_IEN, 8'h00);
    rchk(LCDFT_IDX_PSC, 8'h00);
    wr(LCDFT_IDX_PSC, 8'hFF);
    rchk(LCDFT_IDX_PSC, 8'h0F);
    wr(LCDFT_IDX_CTRL, 8'hFF);
    rchk(LCDFT_IDX_CTRL, LCDFT_CTRL_MASK);
    wr(LCDFT_IDX_CTRL, 8'h00);
    wr(10'h000, 8'h5A);
    rchk(10'h000, 8'h00);
    wr(10'h11F, 8'h3C);
    wb(1'b1, 10'h11F, 8'hA5, 1'b0);
    rchk(10'h11F, 8'h3C);
    wr(LCDFT_IDX_SEGSEL, 8'h00);
    cmp(lcdf, 32'h0000_0000);
    cmp(pout, pen);
    wr(LCDFT_IDX_SEGSEL, 8'hFF);
    wr(LCDFT_IDX_CTRL, {6'h00, LCDFT_MUX_4});
    cmp(comf, 3'h7);
    cmp(lcdf, 32'h1FFF_FFFF);
    cmp(pout, 32'h0000_0000);
    for (int k = 0; k < 16; k++) wr(10'h110 + k[9:0], (k == 0) ? 8'h01 : 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(LCDFT_IDX_PSC, {4'h0, psc_t[k]});
      wr(LCDFT_IDX_CTRL, 8'h84 | {6'h00, mux_t[k]});
      wait_frames(3);
      cmp(act, 1'b1);
      cmp(flen, div_t[k] * (psc_t[k] + 1) * 4);
      if (k == 0) cmp({dark1, dark0}, 2'h1);
      if (k == 1) cmp(lcdf, 32'h7FFF_FFFF);
    end
    wr(LCDFT_IDX_PSC, 8'h00);
    wr(LCDFT_IDX_CTRL, 8'h8C);
    cmp(rcen, 1'b1);
    wr(LCDFT_IDX_CTRL, 8'h88);
    cmp(rcen, 1'b1);
    wait_frames(3);
    cmp(flen, 512);
    wr(LCDFT_IDX_CTRL, 8'h84);
    cmp(rcen, 1'b0);
    wr(LCDFT_IDX_FLAG, 8'h00);
    wr(LCDFT_IDX_IEN, 8'h80);
    wait_frames(2);
    cmp(irq, 1'b1);
    rchk(LCDFT_IDX_FLAG, 8'h80);
    wait_frames(1);
    cmp(irq, 1'b1);
    wr(LCDFT_IDX_FLAG, 8'h00);
    rchk(LCDFT_IDX_FLAG, 8'h00);
    wr(LCDFT_IDX_IEN, 8'h00);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b0);
    wr(LCDFT_IDX_CTRL, 8'hD4);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    cmp({act, bias}, 2'h0);
    cmp(coml, 8'h00);
    cmp(segl, 64'h0);
    sleep <= 1'b0;
    repeat (4) @(posedge clk);
    cmp({act, bias}, 2'h3);
    wr(LCDFT_IDX_CTRL, 8'h84);
    sleep <= 1'b1;
    wr(10'h111, 8'hFF);
    wait_frames(2);
    cmp(act, 1'b1);
    sleep <= 1'b0;
    rchk(10'h111, 8'h00);
    wr(LCDFT_IDX_CTRL, 8'h80);
    sleep <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(act, 1'b0);
    sleep <= 1'b0;
    wr(LCDFT_IDX_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    cmp(act, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
